// ### shared/rqf_pkg.sv
/*
 * Package for the receive queue filter control block: register layout,
 * offsets, reset values, frame descriptor, receive states and pause timing.
 * Assumes a 20 MHz core clock and a MAC front end that delivers one
 * descriptor per received frame on the same clock.
 */
// Functional notes
// - While flush is set, queue output flush is high and frame pointer sits at zero.
// - UDP checksum check enabled: UDP frames with bad checksum are dropped.
// - TCP checksum check enabled: TCP frames with bad checksum are dropped.
// - IP checksum check enabled: IP frames with bad header checksum are dropped.
// - Individual filter enabled (reset default): unicast frames hitting the filter pass.
// - Full duplex with pause honour: PAUSE frames hold transmit until timer expires.
// - Bad CRC frames are admitted only when admission is enabled.
// - Group filter enabled: multicast frames other than broadcast hitting the filter pass.
// - Broadcast enabled: every broadcast frame passes.
// - All-group enabled: every multicast frame, broadcast included, passes.
// - Own-address enabled: unicast frames equal to the station address pass.
// - Promiscuous enabled: every frame passes regardless of destination.
// - Inverse filtering accepts frames the normal address check rejects.
// - Run starts reception; clearing it stops only after the current frame.
// - Station address is the 48 bits of the high, mid and low registers.
package rqf_pkg;

  typedef struct packed {
    logic receive_queue_flush;
    logic udp_checksum_discard_en;
    logic tcp_checksum_discard_en;
    logic ip_checksum_discard_en;
    logic individual_addr_filter_en;
    logic pause_honour_en;
    logic bad_crc_admit_en;
    logic group_addr_filter_en;
    logic broadcast_accept_en;
    logic all_group_accept_en;
    logic own_address_accept_en;
    logic promiscuous_en;
    logic [1:0] spare;
    logic inverse_filter_en;
    logic receive_run;
  } rqf_rxctl_t;

  localparam logic [15:0] RFC_RESET = 16'h0800;
  localparam logic [15:0] SA_RESET = 16'h0000;
  localparam logic [8:0] RFC_OFS = 9'h174;
  localparam logic [8:0] SA_LOW_OFS = 9'h110;
  localparam logic [8:0] SA_MID_OFS = 9'h112;
  localparam logic [8:0] SA_HIGH_OFS = 9'h114;
  localparam logic [8:0] STAT_OFS = 9'h1F0;

  typedef struct packed {
    logic [47:0] dest_addr;
    logic table_hit;
    logic crc_err;
    logic is_ip;
    logic ip_sum_err;
    logic is_tcp;
    logic tcp_sum_err;
    logic is_udp;
    logic udp_sum_err;
    logic is_pause;
    logic [15:0] pause_quanta;
  } rqf_frame_t;

  typedef enum logic [1:0] {
    RX_STOPPED = 2'b00,
    RX_IDLE = 2'b01,
    RX_FRAME = 2'b10
  } rqf_rx_state_t;

  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PAUSE_QUANTUM_NS = 5120;
  localparam int unsigned QUANTUM_CYC = (PAUSE_QUANTUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] QUANTUM_LAST = 7'(QUANTUM_CYC - 1);

  typedef struct packed {
    rqf_rxctl_t ctrl;
    logic [15:0] sa_low;
    logic [15:0] sa_mid;
    logic [15:0] sa_high;
    rqf_rx_state_t rx_state;
    logic running;
    logic dup_meta;
    logic dup_sync;
    logic [11:0] frame_ptr;
    logic accept_p;
    logic drop_p;
    logic flush_out;
    logic pause_hold;
    logic [15:0] pause_left;
    logic [6:0] pause_sub;
    logic [15:0] rdata;
    logic rvalid;
  } rqf_state_t;

endpackage : rqf_pkg

// ### hdl/rqf_ctrl.sv
/*
 * Receive queue filter control: control and station address registers,
 * receive run state, frame admission decision, queue flush and the pause
 * timer that holds transmission in full duplex.
 * Assumes descriptors arrive on core_clk from the MAC front end, and that
 * the duplex status comes from the PHY, asynchronous to core_clk.
 */
`timescale 1ns/10ps
module rqf_ctrl import rqf_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [8:0] reg_addr,
  input wire logic [1:0] reg_be,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Frames from the MAC front end.
  input wire logic rx_start,
  input wire logic rx_done,
  input wire rqf_frame_t rx_frame,
  // Link status.
  input wire logic full_duplex,
  // Receive queue side.
  output logic q_accept,
  output logic q_drop,
  output logic queue_flush,
  output logic [11:0] rx_frame_ptr,
  output logic rx_running,
  // Transmit side.
  output logic tx_pause_hold
);

  rqf_state_t st_reg;
  rqf_state_t st_next;

  logic [47:0] station;
  logic is_group;
  logic is_bcast;
  logic addr_match;
  logic addr_ok;
  logic discard;
  logic judge;
  logic accept;
  logic pause_act;

  // The first octet on the wire sits in dest_addr[47:40]; its low bit marks a group address.
  assign station = {st_reg.sa_high, st_reg.sa_mid, st_reg.sa_low};
  assign is_group = rx_frame.dest_addr[40];
  assign is_bcast = &rx_frame.dest_addr;

  // Normal address check; promiscuous mode is left out so inversion cannot starve it.
  assign addr_match = (st_reg.ctrl.broadcast_accept_en && is_bcast) ||
                      (st_reg.ctrl.all_group_accept_en && is_group) ||
                      (st_reg.ctrl.own_address_accept_en && !is_group &&
                       rx_frame.dest_addr == station) ||
                      (st_reg.ctrl.individual_addr_filter_en && !is_group && rx_frame.table_hit) ||
                      (st_reg.ctrl.group_addr_filter_en && is_group && !is_bcast &&
                       rx_frame.table_hit);
  assign addr_ok = st_reg.ctrl.promiscuous_en ||
                   (st_reg.ctrl.inverse_filter_en ? !addr_match : addr_match);

  assign discard = (rx_frame.crc_err && !st_reg.ctrl.bad_crc_admit_en) ||
                   (st_reg.ctrl.udp_checksum_discard_en && rx_frame.is_udp && rx_frame.udp_sum_err) ||
                   (st_reg.ctrl.tcp_checksum_discard_en && rx_frame.is_tcp && rx_frame.tcp_sum_err) ||
                   (st_reg.ctrl.ip_checksum_discard_en && rx_frame.is_ip && rx_frame.ip_sum_err);

  // Only a frame that began while running is judged; others are ignored whole.
  assign judge = st_reg.rx_state == RX_FRAME && rx_done;
  assign accept = judge && addr_ok && !discard && !st_reg.ctrl.receive_queue_flush;
  assign pause_act = st_reg.ctrl.pause_honour_en && st_reg.dup_sync;

  always_comb begin
    st_next = st_reg;
    st_next.dup_meta = full_duplex;
    st_next.dup_sync = st_reg.dup_meta;

    if (reg_wr) begin
      unique case (reg_addr)
        RFC_OFS: begin
          if (reg_be[0]) st_next.ctrl[7:0] = reg_wdata[7:0];
          if (reg_be[1]) st_next.ctrl[15:8] = reg_wdata[15:8];
        end
        SA_LOW_OFS: begin
          if (reg_be[0]) st_next.sa_low[7:0] = reg_wdata[7:0];
          if (reg_be[1]) st_next.sa_low[15:8] = reg_wdata[15:8];
        end
        SA_MID_OFS: begin
          if (reg_be[0]) st_next.sa_mid[7:0] = reg_wdata[7:0];
          if (reg_be[1]) st_next.sa_mid[15:8] = reg_wdata[15:8];
        end
        SA_HIGH_OFS: begin
          if (reg_be[0]) st_next.sa_high[7:0] = reg_wdata[7:0];
          if (reg_be[1]) st_next.sa_high[15:8] = reg_wdata[15:8];
        end
        default: begin
        end
      endcase
    end

    st_next.rvalid = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        RFC_OFS: st_next.rdata = st_reg.ctrl;
        SA_LOW_OFS: st_next.rdata = st_reg.sa_low;
        SA_MID_OFS: st_next.rdata = st_reg.sa_mid;
        SA_HIGH_OFS: st_next.rdata = st_reg.sa_high;
        STAT_OFS: st_next.rdata = {st_reg.rx_state, st_reg.pause_hold, 1'b0, st_reg.frame_ptr};
        default: st_next.rdata = 16'h0000;
      endcase
    end

    unique case (st_reg.rx_state)
      RX_STOPPED: begin
        if (st_reg.ctrl.receive_run) st_next.rx_state = RX_IDLE;
      end
      RX_IDLE: begin
        if (!st_reg.ctrl.receive_run) st_next.rx_state = RX_STOPPED;
        else if (rx_start) st_next.rx_state = RX_FRAME;
      end
      RX_FRAME: begin
        // A cleared run bit waits here for the end of the frame in progress.
        if (rx_done) st_next.rx_state = st_reg.ctrl.receive_run ? RX_IDLE : RX_STOPPED;
      end
      default: st_next.rx_state = RX_STOPPED;
    endcase
    // The run flag is registered so that rx_running leaves a flip-flop without a decode behind it.
    st_next.running = st_next.rx_state != RX_STOPPED;

    st_next.accept_p = accept;
    st_next.drop_p = judge && !accept;
    st_next.flush_out = st_reg.ctrl.receive_queue_flush;
    if (st_reg.ctrl.receive_queue_flush) st_next.frame_ptr = 12'h000;
    else if (accept) st_next.frame_ptr = st_reg.frame_ptr + 12'h001;

    // A PAUSE frame with a good CRC reloads the timer; zero quanta releases at once.
    if (!pause_act) begin
      st_next.pause_hold = 1'b0;
      st_next.pause_left = 16'h0000;
      st_next.pause_sub = 7'h00;
    end else if (judge && rx_frame.is_pause && !rx_frame.crc_err) begin
      st_next.pause_left = rx_frame.pause_quanta;
      st_next.pause_sub = 7'h00;
      st_next.pause_hold = rx_frame.pause_quanta != 16'h0000;
    end else if (st_reg.pause_hold) begin
      if (st_reg.pause_sub == QUANTUM_LAST) begin
        st_next.pause_sub = 7'h00;
        st_next.pause_left = st_reg.pause_left - 16'h0001;
        if (st_reg.pause_left == 16'h0001) st_next.pause_hold = 1'b0;
      end else begin
        st_next.pause_sub = st_reg.pause_sub + 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.ctrl <= rqf_rxctl_t'(RFC_RESET);
      st_reg.sa_low <= SA_RESET;
      st_reg.sa_mid <= SA_RESET;
      st_reg.sa_high <= SA_RESET;
      st_reg.rx_state <= RX_STOPPED;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign reg_rvalid = st_reg.rvalid;
  assign q_accept = st_reg.accept_p;
  assign q_drop = st_reg.drop_p;
  assign queue_flush = st_reg.flush_out;
  assign rx_frame_ptr = st_reg.frame_ptr;
  assign rx_running = st_reg.running;
  assign tx_pause_hold = st_reg.pause_hold;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  AST_FLUSH_CLEARS: assert property (
    st_reg.ctrl.receive_queue_flush |=> queue_flush && rx_frame_ptr == 12'h000)
    else $error("flush did not clear the queue pointer");
  AST_UDP_DROP: assert property (
    judge && st_reg.ctrl.udp_checksum_discard_en && rx_frame.is_udp && rx_frame.udp_sum_err
    |=> q_drop && !q_accept)
    else $error("bad UDP checksum frame was queued");
  AST_TCP_DROP: assert property (
    judge && st_reg.ctrl.tcp_checksum_discard_en && rx_frame.is_tcp && rx_frame.tcp_sum_err
    |=> q_drop && !q_accept)
    else $error("bad TCP checksum frame was queued");
  AST_IP_DROP: assert property (
    judge && st_reg.ctrl.ip_checksum_discard_en && rx_frame.is_ip && rx_frame.ip_sum_err
    |=> q_drop && !q_accept)
    else $error("bad IP checksum frame was queued");
  AST_CRC_DROP: assert property (
    judge && rx_frame.crc_err && !st_reg.ctrl.bad_crc_admit_en |=> !q_accept)
    else $error("CRC error frame was queued");
  AST_PROMISC: assert property (
    judge && st_reg.ctrl.promiscuous_en && !discard && !st_reg.ctrl.receive_queue_flush |=> q_accept)
    else $error("promiscuous frame was not queued");
  AST_BCAST: assert property (
    judge && is_bcast && st_reg.ctrl.broadcast_accept_en && !st_reg.ctrl.inverse_filter_en && !discard
    && !st_reg.ctrl.receive_queue_flush |=> q_accept)
    else $error("broadcast frame was not queued");
  AST_OWN_ADDR: assert property (
    judge && st_reg.ctrl.own_address_accept_en && !st_reg.ctrl.inverse_filter_en && !is_group
    && rx_frame.dest_addr == station && !discard && !st_reg.ctrl.receive_queue_flush |=> q_accept)
    else $error("own address frame was not queued");
  AST_INVERSE: assert property (
    judge && st_reg.ctrl.inverse_filter_en && !st_reg.ctrl.promiscuous_en && addr_match |=> !q_accept)
    else $error("inverse filter queued a matching frame");
  AST_STOP_DRAIN: assert property (
    st_reg.rx_state == RX_FRAME && !st_reg.ctrl.receive_run ##0 !rx_done [*2]
    |=> st_reg.rx_state == RX_FRAME && rx_running)
    else $error("reception stopped inside a frame");
  AST_PAUSE_HOLD: assert property (
    pause_act && judge && rx_frame.is_pause && !rx_frame.crc_err && rx_frame.pause_quanta > 16'h0001
    |=> tx_pause_hold [*8])
    else $error("pause frame did not hold transmission");
  AST_PAUSE_OFF: assert property (
    !st_reg.ctrl.pause_honour_en |=> !tx_pause_hold)
    else $error("pause hold without flow control");
  AST_HALF_DUPLEX: assert property (
    !st_reg.dup_sync |=> !tx_pause_hold)
    else $error("pause hold in half duplex");
  AST_INDIV_HIT: assert property (
    judge && st_reg.ctrl.individual_addr_filter_en && !st_reg.ctrl.inverse_filter_en && !is_group
    && rx_frame.table_hit && !discard && !st_reg.ctrl.receive_queue_flush |=> q_accept)
    else $error("filtered individual frame was not queued");
  AST_GROUP_HIT: assert property (
    judge && st_reg.ctrl.group_addr_filter_en && !st_reg.ctrl.inverse_filter_en && is_group && !is_bcast
    && rx_frame.table_hit && !discard && !st_reg.ctrl.receive_queue_flush |=> q_accept)
    else $error("filtered group frame was not queued");
  AST_ALL_GROUP: assert property (
    judge && st_reg.ctrl.all_group_accept_en && !st_reg.ctrl.inverse_filter_en && is_group && !discard
    && !st_reg.ctrl.receive_queue_flush |=> q_accept)
    else $error("group frame was not queued");
  AST_ONE_ANSWER: assert property (
    judge |=> q_accept != q_drop)
    else $error("judged frame did not get exactly one answer");
  AST_NO_ANSWER: assert property (
    !judge |=> !q_accept && !q_drop)
    else $error("answer without a judged frame");
  AST_DISCARD: assert property (
    judge && discard |=> q_drop)
    else $error("discarded frame was not dropped");
  AST_PTR_HOLD: assert property (
    !st_reg.ctrl.receive_queue_flush && !accept |=> $stable(rx_frame_ptr))
    else $error("frame pointer moved without an admitted frame");
  AST_RUN_START: assert property (
    st_reg.rx_state == RX_STOPPED && st_reg.ctrl.receive_run |=> rx_running)
    else $error("receive block did not start");

  CVR_ACCEPT: cover property (judge ##1 q_accept);
  CVR_DRAIN: cover property (st_reg.rx_state == RX_FRAME && !st_reg.ctrl.receive_run ##[1:20] !rx_running);
  CVR_PAUSE: cover property ($rose(tx_pause_hold) ##[1:300] $fell(tx_pause_hold));
  CVR_FLUSH: cover property (queue_flush ##1 !queue_flush);
  CVR_INVERSE: cover property (judge && st_reg.ctrl.inverse_filter_en && !addr_match ##1 q_accept);

endmodule : rqf_ctrl

// ### sim/rqf_station.sv
/*
 * Remote station model: turns one bench request into one framed descriptor.
 * Assumes go is raised for a single cycle and only while no frame is in flight.
 */
`timescale 1ns/10ps
module rqf_station import rqf_pkg::*; (
  // Clock.
  input wire logic core_clk,
  // Request from the bench.
  input wire logic go,
  input wire logic [7:0] len,
  input wire rqf_frame_t desc,
  // Frame side.
  output logic rx_start,
  output logic rx_done,
  output rqf_frame_t rx_frame
);
  initial begin
    rx_start = 1'h0;
    rx_done = 1'h0;
    rx_frame = '0;
  end
  // After each done cycle the descriptor is inverted, so a stale value cannot pass for a fresh one.
  always @(posedge core_clk) begin
    if (go) begin
      #2 rx_start = 1'h1;
      @(posedge core_clk) #2 rx_start = 1'h0;
      repeat (len) @(posedge core_clk);
      #2 rx_frame = desc;
      rx_done = 1'h1;
      @(posedge core_clk) #2 rx_done = 1'h0;
      rx_frame = ~desc;
    end
  end
endmodule : rqf_station

// ### sim/rqf_ctrl_bench.sv
/*
 * Self-checking bench for the receive queue filter control block.
 * Assumes the remote station model drives the frame port and the bench owns the register port.
 */
`timescale 1ns/10ps
module rqf_ctrl_bench import rqf_pkg::*;;
  typedef struct packed {
    logic [15:0] c;
    logic [47:0] d;
    logic h;
    logic [3:0] e;
    logic x;
  } rqf_row_t;
  localparam logic [47:0] SA = 48'h0210_3344_5566;
  localparam logic [47:0] OTHER = 48'h0210_3344_5567;
  localparam logic [47:0] MC = 48'h0100_0000_0001;
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
  logic core_clk = 1'h0;
  logic reset_n, reg_wr, reg_rd, reg_rvalid, rx_start, rx_done, full_duplex, go;
  logic q_accept, q_drop, queue_flush, rx_running, tx_pause_hold;
  logic [8:0] reg_addr;
  logic [1:0] reg_be;
  logic [15:0] reg_wdata, reg_rdata;
  logic [11:0] rx_frame_ptr;
  logic [7:0] len;
  rqf_frame_t rx_frame, desc, pf;
  int checks, miscompares, accepts, n;
  rqf_row_t rows [19] = '{
    '{16'h0021, SA, 1'h0, 4'h0, 1'h1},
    '{16'h0021, OTHER, 1'h0, 4'h0, 1'h0},
    '{16'h0801, OTHER, 1'h1, 4'h0, 1'h1},
    '{16'h0801, OTHER, 1'h0, 4'h0, 1'h0},
    '{16'h0101, MC, 1'h1, 4'h0, 1'h1},
    '{16'h0101, MC, 1'h0, 4'h0, 1'h0},
    '{16'h0081, BC, 1'h0, 4'h0, 1'h1},
    '{16'h0001, BC, 1'h0, 4'h0, 1'h0},
    '{16'h0041, MC, 1'h0, 4'h0, 1'h1},
    '{16'h0041, BC, 1'h0, 4'h0, 1'h1},
    '{16'h0011, OTHER, 1'h0, 4'h0, 1'h1},
    '{16'h0023, OTHER, 1'h0, 4'h0, 1'h1},
    '{16'h0023, SA, 1'h0, 4'h0, 1'h0},
    '{16'h0011, OTHER, 1'h0, 4'h8, 1'h0},
    '{16'h0211, OTHER, 1'h0, 4'h8, 1'h1},
    '{16'h4011, OTHER, 1'h0, 4'h1, 1'h0},
    '{16'h0011, OTHER, 1'h0, 4'h1, 1'h1},
    '{16'h2011, OTHER, 1'h0, 4'h2, 1'h0},
    '{16'h1011, OTHER, 1'h0, 4'h4, 1'h0}
  };
  rqf_ctrl dut_u (.core_clk, .reset_n, .reg_addr, .reg_be, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .rx_start, .rx_done, .rx_frame, .full_duplex, .q_accept, .q_drop, .queue_flush,
    .rx_frame_ptr, .rx_running, .tx_pause_hold);
  rqf_station stn_u (.core_clk, .go, .len, .desc, .rx_start, .rx_done, .rx_frame);
  always #25 core_clk = ~core_clk;
  task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : compare
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #2;
  endtask : tick
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    tick(1);
    reg_wr = 1'h0;
    tick(1);
  endtask : wr
  // A missing valid pulse turns the data into the inverse of the expected value, so it cannot match by chance.
  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    reg_addr = a;
    reg_rd = 1'h1;
    tick(1);
    reg_rd = 1'h0;
    compare(reg_rvalid ? reg_rdata : ~e, e);
    tick(1);
  endtask : rd
  task automatic send(input rqf_frame_t f, input logic [7:0] l);
    desc = f;
    len = l;
    go = 1'h1;
    tick(1);
    go = 1'h0;
  endtask : send
  task automatic await(input logic [15:0] e);
    for (int i = 0; i < 40 && !(q_accept | q_drop); i++) tick(1);
    if (e == 16'h0001) accepts++;
    compare(16'({q_drop, q_accept}), e);
  endtask : await
  function automatic rqf_frame_t mkf(input logic [47:0] da, input logic hit, input logic [3:0] err);
    mkf = '0;
    mkf.dest_addr = da;
    mkf.table_hit = hit;
    {mkf.crc_err, mkf.ip_sum_err, mkf.tcp_sum_err, mkf.udp_sum_err} = err;
    {mkf.is_ip, mkf.is_tcp, mkf.is_udp} = {|err[2:0], err[1:0]};
  endfunction : mkf
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #500000;
    miscompares++;
    give_verdict();
  end
  initial begin
    {reset_n, reg_wr, reg_rd, go, len, reg_wdata, reg_addr} = '0;
    reg_be = 2'h3;
    full_duplex = 1'h1;
    desc = '0;
    tick(12);
    reset_n = 1'h1;
    tick(1);
    rd(RFC_OFS, RFC_RESET);
    wr(SA_LOW_OFS, 16'h5566);
    wr(SA_MID_OFS, 16'h3344);
    wr(SA_HIGH_OFS, 16'h0210);
    rd(SA_HIGH_OFS, 16'h0210);
    rd(9'h1F2, 16'h0000);
    $display("register test done");
    foreach (rows[i]) begin
      wr(RFC_OFS, rows[i].c);
      tick(2);
      send(mkf(rows[i].d, rows[i].h, rows[i].e), 8'h02);
      await(rows[i].x ? 16'h0001 : 16'h0002);
    end
    compare(16'(rx_frame_ptr), 16'(accepts));
    $display("filter rows done");
    send(mkf(OTHER, 1'h0, 4'h0), 8'h08);
    wr(RFC_OFS, 16'h0010);
    await(16'h0001);
    tick(1);
    compare(16'(rx_running), 16'h0000);
    send(mkf(OTHER, 1'h0, 4'h0), 8'h02);
    await(16'h0000);
    rd(STAT_OFS, 16'(accepts[11:0]));
    $display("stop test done");
    wr(RFC_OFS, 16'h0411);
    tick(2);
    pf = mkf(OTHER, 1'h0, 4'h0);
    pf.is_pause = 1'h1;
    pf.pause_quanta = 16'h0001;
    send(pf, 8'h02);
    await(16'h0001);
    n = 0;
    repeat (300) begin
      if (tx_pause_hold === 1'h1) n++;
      tick(1);
    end
    compare(16'(n), 16'(QUANTUM_CYC));
    pf.pause_quanta = 16'h0002;
    send(pf, 8'h02);
    await(16'h0001);
    tick(10);
    wr(RFC_OFS, 16'h0011);
    tick(1);
    compare(16'(tx_pause_hold), 16'h0000);
    // Half duplex is entered only with pause honour already cleared.
    full_duplex = 1'h0;
    send(pf, 8'h02);
    await(16'h0001);
    tick(4);
    compare(16'(tx_pause_hold), 16'h0000);
    $display("pause test done");
    // Run is cleared before the flush and the flush bit cleared afterwards.
    wr(RFC_OFS, 16'h0010);
    wr(RFC_OFS, 16'h8010);
    tick(1);
    compare(16'({queue_flush, rx_frame_ptr}), 16'h1000);
    wr(RFC_OFS, 16'h0011);
    tick(2);
    compare(16'(queue_flush), 16'h0000);
    send(mkf(OTHER, 1'h0, 4'h0), 8'h02);
    await(16'h0001);
    compare(16'(rx_frame_ptr), 16'h0001);
    $display("flush test done");
    reset_n = 1'h0;
    tick(1);
    compare(16'({queue_flush, rx_running, tx_pause_hold, rx_frame_ptr}), 16'h0000);
    reset_n = 1'h1;
    tick(1);
    rd(RFC_OFS, RFC_RESET);
    rd(SA_LOW_OFS, SA_RESET);
    $display("reset test done");
    give_verdict();
  end
endmodule : rqf_ctrl_bench
